// *** core/ram_user_program_partition.sv ***
`timescale 1ns/100ps
// Behaviour
// [RQ1] Bits 31 to 16 of the user program base register always read as zero.
// [RQ2] Bits 15 to 10 are read/write and give the user program start within RAM.
// [RQ3] Software must set the user program base above the user data base.
// [RQ4] Bits 9 to 0 always read as zero, so the base moves in 1 KB steps.
// [RQ5] Any reset clears the user program base register to zero.
// [RQ6] Software must keep the user program base at or below the RAM size value.
// [RQ7] A low level on master_clear_n puts the block into reset.
// [RQ8] Writes to the read-only and unimplemented bits are ignored.
module ram_user_program_partition
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic master_clear_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [partition_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] user_data_base,
	input wire logic [31:0] ram_size_value,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] user_program_base,
	output logic device_reset_n
);
	import partition_pkg::*;

	// ----------------------------------------
	// Reset
	// ----------------------------------------
	logic rst_n;

	reset_filter u_reset_filter
	(
		.pclk(pclk),
		.presetn(presetn),
		.master_clear_n(master_clear_n),
		.block_rst_n(rst_n)
	);

	assign device_reset_n = rst_n; // RQ7

	// ----------------------------------------
	// Register
	// ----------------------------------------
	logic [FIELD_W-1:0] base_field;
	logic [FIELD_W-1:0] next_base_field;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic access;
	logic hit_base;
	logic hit_status;
	logic hit_data;
	logic hit_size;
	logic [31:0] base_word;
	logic below_data;
	logic above_size;

	assign access = psel && penable;
	assign hit_base = paddr == OFF_USER_PROGRAM_BASE;
	assign hit_status = paddr == OFF_PARTITION_STATUS;
	assign hit_data = paddr == OFF_USER_DATA_BASE;
	assign hit_size = paddr == OFF_RAM_SIZE_VALUE;

	// Upper and lower bits are constant zero, never stored
	assign base_word = {16'h0000, base_field, 10'h000}; // RQ1 RQ4
	assign user_program_base = base_word;

	// Only reported: the device cannot refuse a mismatching partition
	assign below_data = (base_field != FIELD_RESET) && (base_word <= user_data_base); // RQ3
	assign above_size = base_word > ram_size_value; // RQ6

	always_comb
	begin
		next_base_field = base_field;
		if (access && pwrite && hit_base && pstrb[1])
		begin
			next_base_field = pwdata[FIELD_MSB:FIELD_LSB]; // RQ2 RQ8
		end
	end

	always_comb
	begin
		next_prdata = prdata;
		next_pslverr = 1'b0;
		if (psel && !penable)
		begin
			next_prdata = 32'h0000_0000;
			if (!pwrite)
			begin
				if (hit_base)
				begin
					next_prdata = base_word;
				end
				else if (hit_status)
				begin
					next_prdata = {30'h0000_0000, above_size, below_data};
				end
				else if (hit_data)
				begin
					next_prdata = user_data_base;
				end
				else if (hit_size)
				begin
					next_prdata = ram_size_value;
				end
			end
			next_pslverr = !(hit_base || hit_status || hit_data || hit_size)
				|| (pwrite && !hit_base);
		end
	end

	always_ff @(posedge pclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			base_field <= FIELD_RESET; // RQ5
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			base_field <= next_base_field;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Access phase always completes in one cycle
	assign pready = 1'b1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_upper_zero;
		@(posedge pclk) disable iff (!rst_n)
		user_program_base[31:16] == 16'h0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero"); // RQ1

	property p_lower_zero;
		@(posedge pclk) disable iff (!rst_n)
		user_program_base[9:0] == 10'h000;
	endproperty
	a_lower_zero: assert property (p_lower_zero) else $error("lower bits not zero"); // RQ4

	sequence s_base_write;
		psel && penable && pwrite && hit_base && pstrb[1];
	endsequence

	property p_write_takes;
		@(posedge pclk) disable iff (!rst_n)
		s_base_write |=> user_program_base[15:10] == $past(pwdata[15:10]);
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("base write lost"); // RQ2

	property p_hold;
		@(posedge pclk) disable iff (!rst_n)
		!(psel && penable && pwrite && hit_base && pstrb[1]) |=> $stable(user_program_base);
	endproperty
	a_hold: assert property (p_hold) else $error("base changed without write"); // RQ8

	property p_readback;
		@(posedge pclk) disable iff (!rst_n)
		(psel && !penable && !pwrite && hit_base) ##1 (psel && penable)
			|-> prdata == user_program_base;
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch"); // RQ2

	property p_reset_clear;
		@(posedge pclk)
		!rst_n |-> user_program_base == USER_PROGRAM_BASE_RESET;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("base not cleared"); // RQ5

	property p_master_clear_n;
		@(posedge pclk)
		!master_clear_n |-> !device_reset_n;
	endproperty
	a_master_clear_n: assert property (p_master_clear_n) else $error("clear pin ignored"); // RQ7

	property p_status;
		@(posedge pclk) disable iff (!rst_n)
		(psel && !penable && !pwrite && hit_status) |=>
			prdata[1:0] == {$past(above_size), $past(below_data)};
	endproperty
	a_status: assert property (p_status) else $error("status wrong"); // RQ3 RQ6

	sequence s_base_read_setup;
		psel && !penable && !pwrite && hit_base;
	endsequence

	property p_read_fixed_bits;
		@(posedge pclk) disable iff (!rst_n)
		s_base_read_setup |=> prdata[31:16] == 16'h0000 && prdata[9:0] == 10'h000 && !pslverr;
	endproperty
	a_read_fixed_bits: assert property (p_read_fixed_bits) else $error("fixed bits wrong"); // RQ1 RQ4

	property p_refused_write;
		@(posedge pclk) disable iff (!rst_n)
		(psel && !penable && pwrite && !hit_base) |=> pslverr;
	endproperty
	a_refused_write: assert property (p_refused_write) else $error("write not refused"); // RQ8

	property p_strobe_gate;
		@(posedge pclk) disable iff (!rst_n)
		(psel && penable && pwrite && hit_base && !pstrb[1]) |=> $stable(user_program_base);
	endproperty
	a_strobe_gate: assert property (p_strobe_gate) else $error("lane 1 gate broken"); // RQ8

	property p_master_clear_n_hold;
		@(posedge pclk)
		!master_clear_n |=> !device_reset_n;
	endproperty
	a_master_clear_n_hold: assert property (p_master_clear_n_hold) else $error("reset released early"); // RQ7

	property p_no_wait;
		@(posedge pclk) disable iff (!rst_n)
		(psel && penable) |-> pready;
	endproperty
	a_no_wait: assert property (p_no_wait) else $error("access phase stalled"); // RQ2
endmodule

// *** core/reset_filter.sv ***
`timescale 1ns/100ps
module reset_filter
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic master_clear_n,
	output logic block_rst_n
);
	import partition_pkg::*;

	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;

	// Assert at once, release only after the chain has seen the clock
	always_comb
	begin
		next_stage = {stage[SYNC_STAGES-2:0], 1'b1};
	end

	always_ff @(posedge pclk or negedge presetn or negedge master_clear_n)
	begin
		if (!presetn || !master_clear_n)
		begin
			stage <= '0;
		end
		else
		begin
			stage <= next_stage;
		end
	end

	assign block_rst_n = stage[SYNC_STAGES-1];
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/100ps
`define CHK(g, e) if ((g) !== (e)) begin mismatches++; $display("mismatch %0t %h %h", $time, g, e); end
module testbench;
	import partition_pkg::*;
	logic pclk = 0, presetn = 0, master_clear_n = 1, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, user_data_base = '0, ram_size_value = '0, prdata, w, m, nm;
	logic [31:0] user_program_base;
	logic [3:0] pstrb = '0, s;
	logic pready, pslverr, device_reset_n;
	logic [32:0] expq[$], exp_v;
	int mismatches = 0, cmp_count = 0, cyc = 0, n, i, k;
	always #12.5 pclk = ~pclk;
	ram_user_program_partition i_dut(.pclk, .presetn, .master_clear_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .user_data_base, .ram_size_value, .prdata, .pready,
		.pslverr, .user_program_base, .device_reset_n);
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Note is {pslverr, prdata}; for writes only the error bit is judged
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [3:0] st, input logic [32:0] e);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= st;
		expq.push_back(e);
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_rst();
		n = 0;
		while (device_reset_n !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
	endtask
	// Read results are judged here, in the access cycle where they stand
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			mismatches++;
			give_verdict();
		end
		if (psel && penable && pready === 1'b1)
		begin
			if (expq.size() == 0)
			begin
				mismatches++;
				$display("mismatch %0t transfer with no expectation", $time);
			end
			else
			begin
				exp_v = expq.pop_front();
				cmp_count++;
				if (pwrite)
				begin
					`CHK(pslverr, exp_v[32])
				end
				else
				begin
					`CHK({pslverr, prdata}, exp_v)
				end
			end
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial
	begin
		void'($urandom(79787));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		wait_rst();
		apb(0, OFF_USER_PROGRAM_BASE, 0, 0, 33'h0_0000_0000);
		m = '0;
		// All ones first so every unimplemented and read-only bit is hit
		for (i = 0; i < 12; i++)
		begin
			w = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			s = (i == 0) ? 4'hF : 4'($urandom);
			nm = s[1] ? (w & USER_PROGRAM_BASE_MASK) : m;
			// Software keeps the data base below a nonzero base and the RAM size at or above the base
			user_data_base <= (nm == 0) ? $urandom : $urandom % nm;
			ram_size_value <= nm + ($urandom % 32'h0001_0000);
			apb(1, OFF_USER_PROGRAM_BASE, w, s, 33'h0_0000_0000);
			m = nm;
			apb(0, OFF_USER_PROGRAM_BASE, 0, 0, {1'b0, m});
			cmp_count++;
			`CHK(user_program_base, m)
			apb(0, OFF_PARTITION_STATUS, 0, 0, 33'h0_0000_0000);
			apb(0, OFF_USER_DATA_BASE, 0, 0, {1'b0, user_data_base});
			apb(0, OFF_RAM_SIZE_VALUE, 0, 0, {1'b0, ram_size_value});
			// Writes to the read-only words are refused and leave the base alone
			apb(1, 12'(OFF_PARTITION_STATUS + 4 * (i % 3)), $urandom, 4'hF, 33'h1_0000_0000);
			apb(0, 12'(12'h010 + 4 * i), 0, 0, 33'h1_0000_0000);
			cmp_count++;
			`CHK(user_program_base, m)
		end
		// Master clear pin first, then the bus reset, each in mid-run
		for (k = 0; k < 2; k++)
		begin
			user_data_base <= '0;
			ram_size_value <= 32'h0000_FC00;
			apb(1, OFF_USER_PROGRAM_BASE, 32'h0000_FC00, 4'hF, 33'h0_0000_0000);
			@(posedge pclk);
			if (k == 0)
				master_clear_n <= 0;
			else
				presetn <= 0;
			@(posedge pclk);
			cmp_count += 2;
			`CHK(device_reset_n, 1'b0)
			`CHK(user_program_base, 32'h0000_0000)
			master_clear_n <= 1;
			presetn <= 1;
			wait_rst();
			apb(0, OFF_USER_PROGRAM_BASE, 0, 0, 33'h0_0000_0000);
		end
		repeat (3) @(posedge pclk);
		give_verdict();
	end
endmodule

// *** shared/partition_pkg.sv ***
package partition_pkg;
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_USER_PROGRAM_BASE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_PARTITION_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_USER_DATA_BASE = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_RAM_SIZE_VALUE = 12'h00C;
	localparam int FIELD_LSB = 10;
	localparam int FIELD_MSB = 15;
	localparam int FIELD_W = FIELD_MSB - FIELD_LSB + 1;
	localparam logic [FIELD_W-1:0] FIELD_RESET = 6'h00;
	localparam logic [31:0] USER_PROGRAM_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] USER_PROGRAM_BASE_MASK = 32'h0000_FC00;
	localparam int SYNC_STAGES = 2;
endpackage
